//--- accum_map.vh
`ifndef ACCUM_MAP_VH
`define ACCUM_MAP_VH

// ----------------------------------------------------------------
// Datapath widths
// ----------------------------------------------------------------
`define ACC_W 58
`define MULA_W 27
`define MULB_W 24
`define PROD_W 51
`define REG_AW 4
`define REG_DW 32
`define HI_W 26

// ----------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------
`define OFS_CTRL 4'h0
`define OFS_MASK_LO 4'h1
`define OFS_MASK_HI 4'h2
`define OFS_PAT_LO 4'h3
`define OFS_PAT_HI 4'h4
`define OFS_RND_LO 4'h5
`define OFS_RND_HI 4'h6
`define OFS_STATUS 4'h7
`define OFS_CLEAR 4'h8
`define OFS_IRQ_EN 4'h9
`define OFS_ACC_LO 4'hA
`define OFS_ACC_HI 4'hB

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CTRL_W 2
`define CTRL_PATTERN_ON 0
`define CTRL_AUTORESET 1
`define CTRL_RESET 2'h0

// ----------------------------------------------------------------
// Status / interrupt fields
// ----------------------------------------------------------------
`define STAT_W 4
`define STAT_OVERFLOW 0
`define STAT_UNDERFLOW 1
`define STAT_PATTERN 2
`define STAT_AUTORESET 3
`define STAT_RESET 4'h0

// ----------------------------------------------------------------
// Pattern detector and rounding constant reset values
// ----------------------------------------------------------------
`define MASK_RESET 58'h0FFFFFFFFFFFFFF
`define PATTERN_RESET 58'h000000000000000
`define RND_RESET 58'h000000000000000

// ----------------------------------------------------------------
// Operand select code fields
// ----------------------------------------------------------------
`define OPSEL_W 4
`define OPSEL_W_LSB 0
`define OPSEL_X_BIT 2
`define OPSEL_Z_BIT 3
`define WSEL_ZERO 2'h0
`define WSEL_ADDEND 2'h1
`define WSEL_STATIC 2'h2

// ----------------------------------------------------------------
// Carry-in source codes
// ----------------------------------------------------------------
`define CSEL_W 3
`define CSEL_INPUT 3'h0
`define CSEL_PROD_SIGN 3'h1
`define CSEL_PROD_SIGN_N 3'h2
`define CSEL_ACC_SIGN 3'h3
`define CSEL_ACC_SIGN_N 3'h4

`endif

//--- pattern_compare.v
`timescale 1ns/100ps
`include "accum_map.vh"

// Masked compare of a word against a pattern and its complement
module pattern_compare (
   input wire [`ACC_W-1:0] value_in,
   input wire [`ACC_W-1:0] pattern_in,
   input wire [`ACC_W-1:0] mask_in,
   output wire match_out,
   output wire match_b_out
);

   wire [`ACC_W-1:0] hit;
   wire [`ACC_W-1:0] hit_b;

   // ----------------------------------------------------------------
   // Per-bit compare, masked bits always agree
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `ACC_W; i = i + 1) begin : bit_cmp
         assign hit[i] = mask_in[i] | ~(value_in[i] ^ pattern_in[i]);
         assign hit_b[i] = mask_in[i] | (value_in[i] ^ pattern_in[i]);
      end
   endgenerate

   // All unmasked bits equal pattern / complement of pattern
   assign match_out = &hit;
   assign match_b_out = &hit_b;

endmodule

//--- accum_round_sat.v
// Summary of operation
// RL1: Default zero pattern and top-two-zero mask flag overflow past accumulator bit 56.
// RL2: Overflow when value rises beyond 0011..1, underflow when it falls beyond 1100..0.
// RL3: Overflow and underflow are single-cycle pulses, never latched.
// RL4: Fabric registers the flags and muxes in max positive or max negative value; sat_fabric delays the result, not the flags.
// RL5: Pattern detection and both flags work only with pattern logic switched on.
// RL6: N mask ones give overflow above 2^N-1 and underflow below -2^N.
// RL7: User keeps at least one guard bit; 57 meaningful output bits remain.
// RL8: Rounding constant holds ones, one fewer than fractional places, e.g. 0000.0111.
// RL9: Round toward zero adds product, constant and sign bit as carry, then truncates.
// RL10: Round toward infinity adds complemented sign, produced internally by carry select.
// RL11: Controller may add constant on first cycle, taking accumulator sign for final carry.
// RL12: Addend input accepts run-time constants; static constant is configuration-only.
// RL13: Convergent rounding uses pattern-detect results plus fabric logic at midpoints.
// RL14: Pattern detector can clear the accumulator once a programmed count matches.
// RL15: Flags derive from the registered accumulator, one cycle after it updates.
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "accum_map.vh"

module accum_round_sat (
   input wire mclk_in,
   input wire reset_n_in,
   input wire [`REG_AW-1:0] reg_addr_in,
   input wire [`REG_DW-1:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output wire [`REG_DW-1:0] reg_rdata_out,
   input wire [`MULA_W-1:0] mult_a_in,
   input wire [`MULB_W-1:0] mult_b_in,
   input wire [`ACC_W-1:0] addend_in,
   input wire [`OPSEL_W-1:0] operand_select_code_in,
   input wire carry_input_in,
   input wire [`CSEL_W-1:0] carry_in_source_select_in,
   output wire [`ACC_W-1:0] result_out,
   output wire pattern_detect_out,
   output wire pattern_b_detect_out,
   output wire overflow_out,
   output wire underflow_out,
   output wire irq_out
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg [`CTRL_W-1:0] ctrl_reg;
   reg [`ACC_W-1:0] mask_reg;
   reg [`ACC_W-1:0] pattern_reg;
   reg [`ACC_W-1:0] static_round_constant_reg;
   reg [`STAT_W-1:0] status_reg;
   reg [`STAT_W-1:0] irq_en_reg;
   reg [`REG_DW-1:0] rdata_reg;
   reg [`ACC_W-1:0] acc_reg;
   reg match_reg;
   reg match_b_reg;
   reg overflow_reg;
   reg underflow_reg;

   reg [`ACC_W-1:0] w_mux;
   reg carry_bit;
   reg [`ACC_W-1:0] acc_next;
   reg [`STAT_W-1:0] status_next;
   reg [`STAT_W-1:0] clear_bits;
   reg [`REG_DW-1:0] rdata_next;

   wire pattern_logic_on;
   wire autoreset_on;
   wire signed [`PROD_W-1:0] product;
   wire [`ACC_W-1:0] prod_ext;
   wire [`ACC_W-1:0] x_mux;
   wire [`ACC_W-1:0] z_mux;
   wire [`ACC_W-1:0] sum;
   wire match_now;
   wire match_b_now;
   wire overflow_next;
   wire underflow_next;
   wire pattern_hit;
   wire autoreset_hit;
   wire [`STAT_W-1:0] events;

   assign pattern_logic_on = ctrl_reg[`CTRL_PATTERN_ON];
   assign autoreset_on = ctrl_reg[`CTRL_AUTORESET];

   // ----------------------------------------------------------------
   // Operand muxes and adder
   // ----------------------------------------------------------------

   // Signed multiply, sign extended to accumulator width
   assign product = $signed(mult_a_in) * $signed(mult_b_in);
   assign prod_ext = {{(`ACC_W-`PROD_W){product[`PROD_W-1]}}, product};

   // Product and accumulator feedback gates
   assign x_mux = operand_select_code_in[`OPSEL_X_BIT] ? prod_ext : {`ACC_W{1'b0}};
   assign z_mux = operand_select_code_in[`OPSEL_Z_BIT] ? acc_reg : {`ACC_W{1'b0}};

   // Third operand: run-time addend or fixed constant
   always @* begin
      case (operand_select_code_in[`OPSEL_W_LSB+1:`OPSEL_W_LSB])
         `WSEL_ADDEND: w_mux = addend_in; // RL12
         `WSEL_STATIC: w_mux = static_round_constant_reg; // RL12
         default: w_mux = {`ACC_W{1'b0}};
      endcase
   end

   // Carry source; sign terms give symmetric rounding
   always @* begin
      case (carry_in_source_select_in)
         `CSEL_PROD_SIGN: carry_bit = product[`PROD_W-1]; // RL9
         `CSEL_PROD_SIGN_N: carry_bit = ~product[`PROD_W-1]; // RL10
         `CSEL_ACC_SIGN: carry_bit = acc_reg[`ACC_W-1]; // RL11
         `CSEL_ACC_SIGN_N: carry_bit = ~acc_reg[`ACC_W-1]; // RL11
         default: carry_bit = carry_input_in;
      endcase
   end

   // Three-way add with carry, wraps modulo accumulator width
   assign sum = w_mux + x_mux + z_mux + {{(`ACC_W-1){1'b0}}, carry_bit}; // RL9

   // ----------------------------------------------------------------
   // Pattern detector
   // ----------------------------------------------------------------

   // Compare the registered accumulator, not the adder output
   pattern_compare u_detect (
      .value_in(acc_reg), // RL15
      .pattern_in(pattern_reg),
      .mask_in(mask_reg),
      .match_out(match_now),
      .match_b_out(match_b_now)
   );

   // Left the pattern or complement region: overflow or underflow
   assign overflow_next = pattern_logic_on & match_reg & ~match_now & ~match_b_now; // RL2
   assign underflow_next = pattern_logic_on & match_b_reg & ~match_now & ~match_b_now; // RL6
   assign pattern_hit = pattern_logic_on & match_now & ~match_reg;
   assign autoreset_hit = pattern_logic_on & autoreset_on & match_now;

   // Accumulator next value with counter auto-clear
   always @* begin
      if (autoreset_hit) begin
         acc_next = {`ACC_W{1'b0}}; // RL14
      end else begin
         acc_next = sum;
      end
   end

   // ----------------------------------------------------------------
   // Accumulator and flag registers
   // ----------------------------------------------------------------

   // Accumulator register, updated every edge
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         acc_reg <= {`ACC_W{1'b0}};
      end else begin
         acc_reg <= acc_next;
      end
   end

   // Detector results, gated by the pattern logic switch
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         match_reg <= 1'b0;
         match_b_reg <= 1'b0;
      end else begin
         match_reg <= pattern_logic_on & match_now; // RL5
         match_b_reg <= pattern_logic_on & match_b_now; // RL13
      end
   end

   // Flags follow the detector one cycle later, one-cycle pulses
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         overflow_reg <= 1'b0;
         underflow_reg <= 1'b0;
      end else begin
         overflow_reg <= overflow_next; // RL3
         underflow_reg <= underflow_next; // RL3
      end
   end

   assign result_out = acc_reg;
   assign pattern_detect_out = match_reg;
   assign pattern_b_detect_out = match_b_reg;
   assign overflow_out = overflow_reg; // RL1
   assign underflow_out = underflow_reg;

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------

   assign events = {autoreset_hit, pattern_hit, underflow_next, overflow_next};

   // Clear from a write to the clear register
   always @* begin
      if (reg_write_in && (reg_addr_in == `OFS_CLEAR)) begin
         clear_bits = reg_wdata_in[`STAT_W-1:0];
      end else begin
         clear_bits = {`STAT_W{1'b0}};
      end
   end

   // New events win over a clear in the same cycle
   always @* begin
      status_next = (status_reg & ~clear_bits) | events;
   end

   assign irq_out = |(status_reg & irq_en_reg);

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------

   // Sticky status, updated every edge
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         status_reg <= `STAT_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   // Interrupt enable register
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         irq_en_reg <= `STAT_RESET;
      end else if (reg_write_in && (reg_addr_in == `OFS_IRQ_EN)) begin
         irq_en_reg <= reg_wdata_in[`STAT_W-1:0];
      end
   end

   // Configuration registers
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl_reg <= `CTRL_RESET;
         mask_reg <= `MASK_RESET;
         pattern_reg <= `PATTERN_RESET;
         static_round_constant_reg <= `RND_RESET;
      end else begin
         if (reg_write_in) begin
            if (reg_addr_in == `OFS_CTRL) begin
               ctrl_reg <= reg_wdata_in[`CTRL_W-1:0];
            end else if (reg_addr_in == `OFS_MASK_LO) begin
               mask_reg[`REG_DW-1:0] <= reg_wdata_in;
            end else if (reg_addr_in == `OFS_MASK_HI) begin
               mask_reg[`ACC_W-1:`REG_DW] <= reg_wdata_in[`HI_W-1:0];
            end else if (reg_addr_in == `OFS_PAT_LO) begin
               pattern_reg[`REG_DW-1:0] <= reg_wdata_in;
            end else if (reg_addr_in == `OFS_PAT_HI) begin
               pattern_reg[`ACC_W-1:`REG_DW] <= reg_wdata_in[`HI_W-1:0];
            end else if (reg_addr_in == `OFS_RND_LO) begin
               static_round_constant_reg[`REG_DW-1:0] <= reg_wdata_in;
            end else if (reg_addr_in == `OFS_RND_HI) begin
               static_round_constant_reg[`ACC_W-1:`REG_DW] <= reg_wdata_in[`HI_W-1:0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------

   // Read mux; unmapped and write-only offsets read zero
   always @* begin
      rdata_next = {`REG_DW{1'b0}};
      if (reg_read_in) begin
         if (reg_addr_in == `OFS_CTRL) begin
            rdata_next = {{(`REG_DW-`CTRL_W){1'b0}}, ctrl_reg};
         end else if (reg_addr_in == `OFS_MASK_LO) begin
            rdata_next = mask_reg[`REG_DW-1:0];
         end else if (reg_addr_in == `OFS_MASK_HI) begin
            rdata_next = {{(`REG_DW-`HI_W){1'b0}}, mask_reg[`ACC_W-1:`REG_DW]};
         end else if (reg_addr_in == `OFS_PAT_LO) begin
            rdata_next = pattern_reg[`REG_DW-1:0];
         end else if (reg_addr_in == `OFS_PAT_HI) begin
            rdata_next = {{(`REG_DW-`HI_W){1'b0}}, pattern_reg[`ACC_W-1:`REG_DW]};
         end else if (reg_addr_in == `OFS_RND_LO) begin
            rdata_next = static_round_constant_reg[`REG_DW-1:0];
         end else if (reg_addr_in == `OFS_RND_HI) begin
            rdata_next = {{(`REG_DW-`HI_W){1'b0}},
                          static_round_constant_reg[`ACC_W-1:`REG_DW]};
         end else if (reg_addr_in == `OFS_STATUS) begin
            rdata_next = {{(`REG_DW-`STAT_W){1'b0}}, status_reg};
         end else if (reg_addr_in == `OFS_IRQ_EN) begin
            rdata_next = {{(`REG_DW-`STAT_W){1'b0}}, irq_en_reg};
         end else if (reg_addr_in == `OFS_ACC_LO) begin
            rdata_next = acc_reg[`REG_DW-1:0];
         end else if (reg_addr_in == `OFS_ACC_HI) begin
            rdata_next = {{(`REG_DW-`HI_W){1'b0}}, acc_reg[`ACC_W-1:`REG_DW]};
         end
      end
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_reg <= {`REG_DW{1'b0}};
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_out = rdata_reg;

endmodule

//--- accum_round_sat_sva.sv
`timescale 1ns/100ps
`include "accum_map.vh"
// --------------------------------------------------------
// Port checker for the rounding accumulator
// --------------------------------------------------------
module accum_round_sat_chk (
   input wire mclk_in,
   input wire reset_n_in,
   input wire [`REG_AW-1:0] reg_addr_in,
   input wire reg_read_in,
   input wire [`REG_DW-1:0] reg_rdata_out,
   input wire [`MULA_W-1:0] mult_a_in,
   input wire [`MULB_W-1:0] mult_b_in,
   input wire [`ACC_W-1:0] addend_in,
   input wire [`OPSEL_W-1:0] operand_select_code_in,
   input wire carry_input_in,
   input wire [`CSEL_W-1:0] carry_in_source_select_in,
   input wire [`ACC_W-1:0] result_out,
   input wire pattern_detect_out,
   input wire pattern_b_detect_out,
   input wire overflow_out,
   input wire underflow_out
);
   // Expected next accumulator, static constant path excluded
   wire signed [`PROD_W-1:0] prod = $signed(mult_a_in) * $signed(mult_b_in);
   wire [2:0] cs = carry_in_source_select_in;
   wire [3:0] op = operand_select_code_in;
   wire ps = prod[`PROD_W-1];
   wire as = result_out[`ACC_W-1];
   wire cy = (cs == `CSEL_PROD_SIGN) ? ps : (cs == `CSEL_PROD_SIGN_N) ? !ps :
      (cs == `CSEL_ACC_SIGN) ? as : (cs == `CSEL_ACC_SIGN_N) ? !as : carry_input_in;
   wire [`ACC_W-1:0] sum = ((op[1:0] == `WSEL_ADDEND) ? addend_in : 58'h0)
      + (op[`OPSEL_X_BIT] ? {{7{ps}}, prod} : 58'h0)
      + (op[`OPSEL_Z_BIT] ? result_out : 58'h0) + {57'h0, cy};

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   a_ovf_cause: assert property (overflow_out ==
      ($past(pattern_detect_out) && !pattern_detect_out && !pattern_b_detect_out))
      else $error("overflow does not follow leaving the pattern region");
   a_unf_cause: assert property (underflow_out ==
      ($past(pattern_b_detect_out) && !pattern_detect_out && !pattern_b_detect_out))
      else $error("underflow does not follow leaving the complement region");
   a_ovf_single: assert property (overflow_out |=> !overflow_out)
      else $error("overflow longer than one cycle");
   a_unf_single: assert property (underflow_out |=> !underflow_out)
      else $error("underflow longer than one cycle");
   a_flag_excl: assert property (!(overflow_out && underflow_out))
      else $error("overflow and underflow together");
   a_acc_sum: assert property ((op[1:0] != `WSEL_STATIC) ##1 !pattern_detect_out
      |-> result_out == $past(sum))
      else $error("accumulator sum wrong");
   a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 32'h0)
      else $error("read data outside read cycle");
   a_rdata_refused: assert property ($past(reg_read_in) && ($past(reg_addr_in) == `OFS_CLEAR
      || $past(reg_addr_in) > `OFS_ACC_HI) |-> reg_rdata_out == 32'h0)
      else $error("write-only or unmapped read not zero");

   c_overflow: cover property (overflow_out);
   c_underflow: cover property (underflow_out);
   c_readback: cover property (reg_read_in ##1 reg_rdata_out != 32'h0);
endmodule

bind accum_round_sat accum_round_sat_chk accum_round_sat_chk_i (.mclk_in(mclk_in),
   .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in),
   .reg_rdata_out(reg_rdata_out), .mult_a_in(mult_a_in), .mult_b_in(mult_b_in),
   .addend_in(addend_in), .operand_select_code_in(operand_select_code_in),
   .carry_input_in(carry_input_in), .carry_in_source_select_in(carry_in_source_select_in),
   .result_out(result_out), .pattern_detect_out(pattern_detect_out),
   .pattern_b_detect_out(pattern_b_detect_out), .overflow_out(overflow_out),
   .underflow_out(underflow_out));

//--- sat_fabric.sv
`timescale 1ns/100ps
`include "accum_map.vh"
// --------------------------------------------------------
// Fabric saturation stage fed by the one-cycle flags
// --------------------------------------------------------
module sat_fabric (
   input wire mclk_in,
   input wire reset_n_in,
   input wire [`ACC_W-1:0] result_in,
   input wire overflow_in,
   input wire underflow_in,
   output wire [`ACC_W-1:0] sat_out
);
   reg [`ACC_W-1:0] result_d_reg;
   reg [`ACC_W-1:0] sat_reg;
   assign sat_out = sat_reg;
   // Flags trail the result by a cycle, so the result is delayed to line up
   always @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         result_d_reg <= 58'h0;
         sat_reg <= 58'h0;
      end else begin
         result_d_reg <= result_in;
         sat_reg <= overflow_in ? 58'h0FFFFFFFFFFFFFF :
            underflow_in ? 58'h300000000000000 : result_d_reg;
      end
   end
endmodule

//--- tb_top.sv
`timescale 1ns/100ps
`include "accum_map.vh"
module tb_top;
   reg mclk_in = 1'b0;
   reg reset_n_in = 1'b0;
   reg [`REG_AW-1:0] reg_addr_in = 4'h0;
   reg [`REG_DW-1:0] reg_wdata_in = 32'h0;
   reg reg_write_in = 1'b0;
   reg reg_read_in = 1'b0;
   reg [`MULA_W-1:0] mult_a_in = 27'h0;
   reg [`MULB_W-1:0] mult_b_in = 24'h0;
   reg [`ACC_W-1:0] addend_in = 58'h0;
   reg [`OPSEL_W-1:0] operand_select_code_in = 4'h0;
   reg carry_input_in = 1'b0;
   reg [`CSEL_W-1:0] carry_in_source_select_in = 3'h0;
   wire [`REG_DW-1:0] reg_rdata_out;
   wire [`ACC_W-1:0] result_out, sat_out;
   wire pattern_detect_out, pattern_b_detect_out, overflow_out, underflow_out, irq_out;
   integer miscompares = 0;
   integer check_count = 0;
   integer ra [0:7] = '{20, -40, 56, 40, -20, 56, 40, 40};
   integer rb [0:7] = '{2, 1, 1, 1, 2, 1, 1, 1};
   integer rc [0:7] = '{1, 1, 1, 2, 2, 2, 0, 1};
   integer rx [0:7] = '{2, -2, 3, 3, -3, 4, 3, 2};
   reg [57:0] mk [0:5] = '{58'h0FFFFFFFFFFFFFF, 58'h0FFFFFFFFFFFFFF, 58'hF, 58'hF, 58'h0,
      58'h0FFFFFFFFFFFFFF};
   reg [57:0] st [0:5] = '{58'h0FFFFFFFFFFFFFF, 58'h300000000000000, 58'hF, 58'h3FFFFFFFFFFFFF0,
      58'h0, 58'h0FFFFFFFFFFFFFF};
   reg [57:0] sp [0:5] = '{58'h1, 58'h3FFFFFFFFFFFFFF, 58'h1, 58'h3FFFFFFFFFFFFFF, 58'h1, 58'h1};
   reg [5:0] eo = 6'h15;
   reg [5:0] eu = 6'h0A;
   reg [5:0] on = 6'h1F;

   // Clock at 40 MHz
   always #12.5 mclk_in = ~mclk_in;

   accum_round_sat accum_round_sat_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
      .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .mult_a_in(mult_a_in),
      .mult_b_in(mult_b_in), .addend_in(addend_in),
      .operand_select_code_in(operand_select_code_in), .carry_input_in(carry_input_in),
      .carry_in_source_select_in(carry_in_source_select_in), .result_out(result_out),
      .pattern_detect_out(pattern_detect_out), .pattern_b_detect_out(pattern_b_detect_out),
      .overflow_out(overflow_out), .underflow_out(underflow_out), .irq_out(irq_out));
   sat_fabric sat_fabric_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .result_in(result_out),
      .overflow_in(overflow_out), .underflow_in(underflow_out), .sat_out(sat_out));

   // --------------------------------------------------------
   // Bus and datapath helpers
   // --------------------------------------------------------
   task chk(input string name, input [57:0] exp, input [57:0] got);
      check_count = check_count + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge mclk_in);
      reg_write_in <= 1'b0;
      #1;
   endtask
   task rdchk(input string name, input [3:0] a, input [31:0] exp, input [31:0] msk);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge mclk_in);
      reg_read_in <= 1'b0;
      #1 chk(name, exp, reg_rdata_out & msk);
   endtask
   task drive(input [3:0] op, input [57:0] add, input [26:0] a, input [23:0] b, input [2:0] cs,
      input ci);
      @(posedge mclk_in);
      operand_select_code_in <= op;
      addend_in <= add;
      mult_a_in <= a;
      mult_b_in <= b;
      carry_in_source_select_in <= cs;
      carry_input_in <= ci;
   endtask

   // --------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------
   task test_reset;
      rdchk("ctrl", `OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      rdchk("mask lo", `OFS_MASK_LO, 32'hFFFFFFFF, 32'hFFFFFFFF);
      rdchk("mask hi", `OFS_MASK_HI, 32'h00FFFFFF, 32'hFFFFFFFF);
      rdchk("status", `OFS_STATUS, 32'h0, 32'hFFFFFFFF);
      rdchk("clear", `OFS_CLEAR, 32'h0, 32'hFFFFFFFF);
      rdchk("unmapped", 4'hC, 32'h0, 32'hFFFFFFFF);
      chk("irq", 58'h0, irq_out);
      $display("test_reset done");
   endtask
   task test_round;
      integer i;
      reg signed [57:0] ev;
      wr(`OFS_RND_LO, 32'h7);
      for (i = 0; i < 8; i = i + 1) begin
         drive((i == 7) ? 4'h6 : 4'h5, 58'h7, ra[i][26:0], rb[i][23:0], rc[i][2:0], i == 6);
         @(posedge mclk_in);
         #1 ev = rx[i];
         chk("round", ev, $signed(result_out) >>> 4);
      end
      $display("test_round done");
   endtask
   task test_macc;
      drive(4'h5, 58'h7, 27'h7FFFFE8, 24'h1, `CSEL_INPUT, 1'b0);
      drive(4'hC, 58'h0, 27'h7FFFFF0, 24'h1, `CSEL_ACC_SIGN, 1'b0);
      @(posedge mclk_in);
      #1 chk("macc", 58'h3FFFFFFFFFFFFFE, $signed(result_out) >>> 4);
      $display("test_macc done");
   endtask
   task test_flags;
      integer i, no, nu;
      reg hit;
      reg [57:0] satv;
      for (i = 0; i < 6; i = i + 1) begin
         wr(`OFS_CTRL, {31'h0, on[i]});
         wr(`OFS_MASK_LO, mk[i][31:0]);
         wr(`OFS_MASK_HI, {6'h0, mk[i][57:32]});
         wr(`OFS_IRQ_EN, 32'h3);
         wr(`OFS_CLEAR, 32'hF);
         drive(4'h1, st[i], 27'h0, 24'h0, `CSEL_INPUT, 1'b0);
         drive(4'h9, sp[i], 27'h0, 24'h0, `CSEL_INPUT, 1'b0);
         drive(4'h8, 58'h0, 27'h0, 24'h0, `CSEL_INPUT, 1'b0);
         no = 0;
         nu = 0;
         hit = 1'b0;
         satv = 58'h0;
         repeat (6) begin
            @(posedge mclk_in);
            #1 if (hit) satv = sat_out;
            hit = overflow_out | underflow_out;
            no = no + overflow_out;
            nu = nu + underflow_out;
         end
         chk("overflow", eo[i], no);
         chk("underflow", eu[i], nu);
         chk("saturate", eo[i] ? 58'h0FFFFFFFFFFFFFF : eu[i] ? 58'h300000000000000 : 58'h0, satv);
         rdchk("sticky", `OFS_STATUS, {30'h0, eu[i], eo[i]}, 32'h3);
         chk("irq", eo[i] | eu[i], irq_out);
         wr(`OFS_IRQ_EN, 32'h0);
         chk("irq masked", 58'h0, irq_out);
         wr(`OFS_IRQ_EN, 32'h3);
         wr(`OFS_CLEAR, 32'h3);
         chk("irq cleared", 58'h0, irq_out);
      end
      $display("test_flags done");
   endtask
   task test_autoreset;
      reg [57:0] mx;
      wr(`OFS_MASK_LO, 32'h0);
      wr(`OFS_MASK_HI, 32'h0);
      wr(`OFS_PAT_LO, 32'h5);
      wr(`OFS_CLEAR, 32'hF);
      drive(4'h0, 58'h0, 27'h0, 24'h0, `CSEL_INPUT, 1'b0);
      wr(`OFS_CTRL, 32'h3);
      drive(4'h8, 58'h0, 27'h0, 24'h0, `CSEL_INPUT, 1'b1);
      mx = 58'h0;
      repeat (12) begin
         @(posedge mclk_in);
         #1 if (result_out > mx) mx = result_out;
      end
      chk("count top", 58'h5, mx);
      rdchk("autoreset", `OFS_STATUS, 32'h8, 32'h8);
      $display("test_autoreset done");
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      test_reset;
      test_round;
      test_macc;
      test_flags;
      test_autoreset;
      print_verdict;
   end

   // Watchdog
   initial begin
      repeat (5000) @(posedge mclk_in);
      miscompares = miscompares + 1;
      print_verdict;
   end
endmodule
